/* File: design/dancer_pid_supervisor.sv */
// dancer control supervisor: enable, limits, set point and speed sum
// Contract
// - upper flag when measure above limit, 9999 off
// - lower flag when measure below limit, 9999 off
// - full-scale input is 100 percent for limits
// - input type selects current, 5V or 10V
// - set point 9999 means fifty percent
// - dancer control only for action 40..43
// - output speed is main speed plus correction
// - input code 14 assigns pid select input
// - no assigned select input: action alone enables
// - action 0 or select off: normal operation
// - pid-active output on while control active
// - forward output on only for forward rotation
// - selector 100 or above inverts output
// - main speed accepted from any operation mode
// - measured input refused as main speed source
// - set point writable while running
module dancer_pid_supervisor (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] pid_action_selection,
  input wire logic [dancer_pkg::SETTING_W-1:0] upper_limit_setting,
  input wire logic [dancer_pkg::SETTING_W-1:0] lower_limit_setting,
  input wire logic [dancer_pkg::SETTING_W-1:0] set_point_setting,
  input wire logic [1:0] measured_input_type,
  input wire logic [dancer_pkg::SEL_W*dancer_pkg::NUM_INPUTS-1:0]
    input_function_select,
  input wire logic [dancer_pkg::NUM_INPUTS-1:0] input_terminals,
  input wire logic [dancer_pkg::SEL_W-1:0] output_function_select_a,
  input wire logic [dancer_pkg::SEL_W-1:0] output_function_select_b,
  input wire logic [dancer_pkg::ADC_W-1:0] position_sample,
  input wire logic [dancer_pkg::SPEED_W-1:0] main_speed,
  input wire logic main_speed_from_measured,
  input wire logic [dancer_pkg::SPEED_W-1:0] pid_correction,
  input wire logic forward_running,
  output logic [dancer_pkg::SPEED_W-1:0] output_speed,
  output logic [dancer_pkg::PCT_W-1:0] pid_set_point,
  output logic [dancer_pkg::PCT_W-1:0] measured_percent,
  output logic dancer_active,
  output logic main_speed_refused,
  output logic upper_limit_flag,
  output logic lower_limit_flag,
  output logic forward_rotation_output,
  output logic terminal_a,
  output logic terminal_b
);
  localparam int N = dancer_pkg::NUM_INPUTS;
  localparam int W = dancer_pkg::SEL_W;

  measure_if meas ();

  logic [N-1:0] sel_sync1;
  logic [N-1:0] sel_sync2;
  logic [N-1:0] assigned;
  logic select_assigned;
  logic select_on;
  logic action_dancer;
  logic next_active;
  logic upper_hit;
  logic lower_hit;

  // a limit setting is active only within 0..100 percent
  function automatic logic limit_on(
    input logic [dancer_pkg::SETTING_W-1:0] s);
    limit_on = (s != dancer_pkg::DISABLED_SETTING) &&
      (s <= dancer_pkg::PCT_FULL_SETTING);
  endfunction : limit_on

  measure_scaler scaler (
    .clk(clk),
    .srst(srst),
    .input_type(measured_input_type),
    .sample(position_sample),
    .m(meas.source)
  );

  // terminal pins are asynchronous to clk
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_sync1 <= '0;
      sel_sync2 <= '0;
    end else begin
      sel_sync1 <= input_terminals;
      sel_sync2 <= sel_sync1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_assign
      assign assigned[i] =
        input_function_select[i*W +: W] ==
        dancer_pkg::IN_FUNC_PID_SELECT;
    end
  endgenerate

  always_comb begin
    select_assigned = |assigned;
    // any assigned terminal that is on selects dancer control
    select_on = |(assigned & sel_sync2);
    action_dancer =
      (pid_action_selection >= dancer_pkg::ACTION_DANCER_FIRST) &&
      (pid_action_selection <= dancer_pkg::ACTION_DANCER_LAST);
    // without an assigned select input, the action setting decides alone
    next_active = action_dancer &&
      (!select_assigned || select_on);
  end

  always_ff @(posedge clk) begin
    if (srst) dancer_active <= 1'b0;
    else dancer_active <= next_active;
  end

  // set point follows its setting every cycle, also while running
  always_ff @(posedge clk) begin
    if (srst) pid_set_point <= dancer_pkg::PCT_HALF;
    else if (set_point_setting == dancer_pkg::DISABLED_SETTING)
      pid_set_point <= dancer_pkg::PCT_HALF;
    else if (set_point_setting > dancer_pkg::PCT_FULL_SETTING)
      pid_set_point <= dancer_pkg::PCT_FULL;
    else
      pid_set_point <= set_point_setting[dancer_pkg::PCT_W-1:0];
  end

  always_comb begin
    upper_hit = dancer_active && meas.valid &&
      limit_on(upper_limit_setting) &&
      ({4'h0, meas.percent} > upper_limit_setting);
    lower_hit = dancer_active && meas.valid &&
      limit_on(lower_limit_setting) &&
      ({4'h0, meas.percent} < lower_limit_setting);
  end

  // flags track the comparison each cycle; no latching
  always_ff @(posedge clk) begin
    if (srst) begin
      upper_limit_flag <= 1'b0;
      lower_limit_flag <= 1'b0;
      measured_percent <= '0;
    end else begin
      upper_limit_flag <= upper_hit;
      lower_limit_flag <= lower_hit;
      measured_percent <= meas.percent;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) forward_rotation_output <= 1'b0;
    else forward_rotation_output <= forward_running;
  end

  // the measured input may not feed the main speed in dancer mode;
  // the main speed itself comes from whichever mode is in charge
  always_ff @(posedge clk) begin
    if (srst) begin
      output_speed <= '0;
      main_speed_refused <= 1'b0;
    end else if (next_active) begin
      main_speed_refused <= main_speed_from_measured;
      if (main_speed_from_measured)
        output_speed <= pid_correction;
      else
        output_speed <= 16'(main_speed + pid_correction);
    end else begin
      main_speed_refused <= 1'b0;
      output_speed <= main_speed;
    end
  end

  // router registers the same level, so terminals switch in the same cycle as the flags
  output_router route_a (
    .clk(clk),
    .srst(srst),
    .select(output_function_select_a),
    .upper(upper_hit),
    .lower(lower_hit),
    .forward(forward_running),
    .pid_active(next_active),
    .terminal(terminal_a)
  );

  output_router route_b (
    .clk(clk),
    .srst(srst),
    .select(output_function_select_b),
    .upper(upper_hit),
    .lower(lower_hit),
    .forward(forward_running),
    .pid_active(next_active),
    .terminal(terminal_b)
  );
endmodule : dancer_pid_supervisor

/* File: design/dancer_pkg.sv */
// shared constants for the dancer supervisor
package dancer_pkg;
  localparam int SETTING_W = 14;
  localparam int PCT_W = 10;
  localparam int SPEED_W = 16;
  localparam int ADC_W = 12;
  localparam int NUM_INPUTS = 5;
  localparam int NUM_OUTPUTS = 2;
  localparam int SEL_W = 8;
  localparam logic [SETTING_W-1:0] DISABLED_SETTING = 14'h270F;
  localparam logic [PCT_W-1:0] PCT_FULL = 10'h3E8;
  localparam logic [PCT_W-1:0] PCT_HALF = 10'h1F4;
  localparam logic [PCT_W-1:0] PCT_LIVE_ZERO = 10'h0C8;
  localparam logic [SETTING_W-1:0] PCT_FULL_SETTING = 14'h03E8;
  localparam logic [7:0] ACTION_OFF = 8'h00;
  localparam logic [7:0] ACTION_DANCER_FIRST = 8'h28;
  localparam logic [7:0] ACTION_DANCER_LAST = 8'h2B;
  localparam logic [SEL_W-1:0] IN_FUNC_PID_SELECT = 8'h0E;
  localparam logic [SEL_W-1:0] OUT_FUNC_LOWER = 8'h0E;
  localparam logic [SEL_W-1:0] OUT_FUNC_UPPER = 8'h0F;
  localparam logic [SEL_W-1:0] OUT_FUNC_FORWARD = 8'h10;
  localparam logic [SEL_W-1:0] OUT_FUNC_PID_ACTIVE = 8'h2F;
  localparam logic [SEL_W-1:0] OUT_FUNC_INVERT = 8'h64;
  localparam logic [1:0] INPUT_CURRENT = 2'h0;
  localparam logic [1:0] INPUT_VOLT5 = 2'h1;
  localparam logic [1:0] INPUT_VOLT10 = 2'h2;
  localparam logic [ADC_W-1:0] ADC_FULL_10V = 12'hFFF;
  localparam logic [ADC_W-1:0] ADC_FULL_5V = 12'h7FF;
  localparam logic [ADC_W-1:0] ADC_LIVE_ZERO = 12'h333;
  localparam logic [ADC_W-1:0] ADC_SPAN_CURRENT = 12'hCCC;
endpackage : dancer_pkg

/* File: design/measure_if.sv */
// scaled measurement carried from the scaler to the supervisor
interface measure_if;
  logic [dancer_pkg::PCT_W-1:0] percent;
  logic valid;
  modport source (output percent, output valid);
  modport sink (input percent, input valid);
endinterface : measure_if

/* File: design/measure_scaler.sv */
// scales the raw position sample to tenths of a percent
module measure_scaler (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] input_type,
  input wire logic [dancer_pkg::ADC_W-1:0] sample,
  measure_if.source m
);
  logic [dancer_pkg::ADC_W-1:0] span;
  logic [dancer_pkg::ADC_W-1:0] base;
  logic [dancer_pkg::ADC_W-1:0] net;
  logic [dancer_pkg::ADC_W+10:0] prod;
  logic [dancer_pkg::ADC_W+10:0] quot;

  // current: 4mA is a live zero at one fifth of the converter span
  always_comb begin
    base = '0;
    span = dancer_pkg::ADC_FULL_10V;
    unique case (input_type)
      dancer_pkg::INPUT_CURRENT: begin
        base = dancer_pkg::ADC_LIVE_ZERO;
        span = dancer_pkg::ADC_SPAN_CURRENT;
      end
      dancer_pkg::INPUT_VOLT5: span = dancer_pkg::ADC_FULL_5V;
      default: span = dancer_pkg::ADC_FULL_10V;
    endcase
    net = (sample > base) ? sample - base : '0;
    if (net > span) net = span;
    prod = {11'h000, net} * 23'(dancer_pkg::PCT_FULL);
    quot = prod / {11'h000, span};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      m.percent <= '0;
      m.valid <= 1'b0;
    end else begin
      m.percent <= quot[dancer_pkg::PCT_W-1:0];
      m.valid <= 1'b1;
    end
  end
endmodule : measure_scaler

/* File: design/output_router.sv */
// maps one output terminal to its selected function and polarity
module output_router (
  input wire logic clk,
  input wire logic srst,
  input wire logic [dancer_pkg::SEL_W-1:0] select,
  input wire logic upper,
  input wire logic lower,
  input wire logic forward,
  input wire logic pid_active,
  output logic terminal
);
  logic [dancer_pkg::SEL_W-1:0] base_code;
  logic invert;
  logic level;

  always_comb begin
    invert = select >= dancer_pkg::OUT_FUNC_INVERT;
    base_code = invert ? select - dancer_pkg::OUT_FUNC_INVERT : select;
    unique case (base_code)
      dancer_pkg::OUT_FUNC_UPPER: level = upper;
      dancer_pkg::OUT_FUNC_LOWER: level = lower;
      dancer_pkg::OUT_FUNC_FORWARD: level = forward;
      dancer_pkg::OUT_FUNC_PID_ACTIVE: level = pid_active;
      default: level = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) terminal <= 1'b0;
    else terminal <= level ^ invert;
  end
endmodule : output_router

/* File: testbench/position_detector.sv */
// dancer roller position detector driving the raw position sample
module position_detector (
  input wire logic clk,
  input wire logic [1:0] kind,
  input wire logic [9:0] target,
  output logic [11:0] sample
);
  timeunit 1ns;
  timeprecision 1ns;
  // current loop keeps a live zero so a broken wire reads below minimum
  always_ff @(posedge clk) begin
    case (kind)
      2'h0: sample <= 12'(12'h333 + (32'(target) * 32'hCCC) / 1000);
      2'h1: sample <= 12'((32'(target) * 32'h7FF) / 1000);
      default: sample <= 12'((32'(target) * 32'hFFF) / 1000);
    endcase
  end
endmodule : position_detector

/* File: testbench/dancer_pid_supervisor_sva.sv */
// assertions on the supervisor ports
module dancer_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic main_speed_from_measured,
  input wire logic dancer_active,
  input wire logic main_speed_refused,
  input wire logic upper_limit_flag,
  input wire logic lower_limit_flag,
  input wire logic terminal_a,
  input wire logic [7:0] pid_action_selection,
  input wire logic [7:0] output_function_select_a,
  input wire logic [1:0] measured_input_type,
  input wire logic [13:0] upper_limit_setting,
  input wire logic [13:0] lower_limit_setting,
  input wire logic [11:0] position_sample,
  input wire logic [15:0] main_speed,
  input wire logic [15:0] pid_correction,
  input wire logic [15:0] output_speed,
  input wire logic [9:0] measured_percent
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence full_in;
    position_sample == 12'hFFF && measured_input_type == 2'h2;
  endsequence
  a_action_range: assert property (
    !(pid_action_selection inside {[8'h28:8'h2B]}) |=> !dancer_active)
    else $error("active outside action range");
  a_speed_sum: assert property (
    dancer_active && !$past(main_speed_from_measured) |->
    output_speed == 16'($past(main_speed) + $past(pid_correction)))
    else $error("speed is not main plus correction");
  a_speed_pass: assert property (
    !dancer_active && !$past(srst) |-> output_speed == $past(main_speed))
    else $error("normal speed not passed");
  a_source_refused: assert property (!$past(srst) |->
    main_speed_refused == (dancer_active && $past(main_speed_from_measured)))
    else $error("refusal flag wrong");
  a_upper_off: assert property (
    $past(upper_limit_setting) == 14'h270F &&
    $past(upper_limit_setting, 2) == 14'h270F |-> !upper_limit_flag)
    else $error("upper flag while disabled");
  a_lower_off: assert property (
    $past(lower_limit_setting) == 14'h270F &&
    $past(lower_limit_setting, 2) == 14'h270F |-> !lower_limit_flag)
    else $error("lower flag while disabled");
  a_full_scale: assert property (
    full_in ##1 full_in ##1 1'b1 |-> measured_percent == 10'h3E8)
    else $error("full scale not hundred percent");
  a_term_pid: assert property (
    $past(output_function_select_a) == 8'h2F && !$past(srst) |->
    terminal_a == dancer_active) else $error("pid terminal wrong");
  a_term_invert: assert property (
    $past(output_function_select_a) == 8'h93 && !$past(srst) |->
    terminal_a != dancer_active) else $error("inverted terminal wrong");
endmodule : dancer_sva

bind dancer_pid_supervisor dancer_sva chk (.clk, .srst,
  .main_speed_from_measured, .dancer_active, .main_speed_refused,
  .upper_limit_flag, .lower_limit_flag, .terminal_a, .pid_action_selection,
  .output_function_select_a, .measured_input_type, .upper_limit_setting,
  .lower_limit_setting, .position_sample, .main_speed, .pid_correction,
  .output_speed, .measured_percent);

/* File: testbench/dancer_pid_supervisor_bench.sv */
// bench for the dancer supervisor
module dancer_pid_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, fwd = 0, from_meas = 0, e;
  logic [7:0] act = 0, sel_a = 0, sel_b = 0;
  logic [13:0] up = 14'h270F, lo = 14'h270F, sp = 14'h270F;
  logic [1:0] kind = 0;
  logic [39:0] in_sel = 0;
  logic [4:0] terms = 0;
  logic [15:0] ms = 0, corr = 0, o_speed, exp_val;
  logic [9:0] target = 0, o_sp, o_pct;
  logic [11:0] sample;
  logic o_act, o_ref, o_up, o_lo, o_fwd, t_a, t_b;
  logic [7:0] codes [8] = '{8'h00, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B,
    8'h2C, 8'h2F};
  logic [9:0] tg [3] = '{10'h384, 10'h1F4, 10'h064};
  int fail_count = 0, compares = 0, seed = 56825;
  initial forever #10 clk = ~clk;
  position_detector pd (.clk, .kind, .target, .sample);
  dancer_pid_supervisor DUT (.clk, .srst, .pid_action_selection(act),
    .upper_limit_setting(up), .lower_limit_setting(lo),
    .set_point_setting(sp), .measured_input_type(kind),
    .input_function_select(in_sel), .input_terminals(terms),
    .output_function_select_a(sel_a), .output_function_select_b(sel_b),
    .position_sample(sample), .main_speed(ms),
    .main_speed_from_measured(from_meas), .pid_correction(corr),
    .forward_running(fwd), .output_speed(o_speed), .pid_set_point(o_sp),
    .measured_percent(o_pct), .dancer_active(o_act),
    .main_speed_refused(o_ref), .upper_limit_flag(o_up),
    .lower_limit_flag(o_lo), .forward_rotation_output(o_fwd),
    .terminal_a(t_a), .terminal_b(t_b));
  function automatic logic exp_act(logic [7:0] a, logic [39:0] s,
      logic [4:0] t);
    logic used = 0;
    logic hit = 0;
    for (int i = 0; i < 5; i++) begin
      used |= s[8*i+:8] == 8'h0E;
      hit |= s[8*i+:8] == 8'h0E && t[i];
    end
    return a inside {[8'h28:8'h2B]} && (!used || hit);
  endfunction : exp_act
  task chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // five edges cover the two-flop terminal sync plus the output register
  task run();
    repeat (5) @(posedge clk);
    #1;
    e = exp_act(act, in_sel, terms);
  endtask : run
  task print_verdict();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(posedge clk);
    srst <= 0;
    sel_a <= 8'h2F;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      act <= codes[i % 8];
      sel_a <= i < 8 ? 8'h2F : 8'h93;
      in_sel <= i < 16 ? 40'h0 : 40'h0E_0000_0000;
      terms <= 5'($random(seed));
      from_meas <= i % 3 == 1;
      ms <= 16'($random(seed));
      corr <= 16'($random(seed));
      run();
      chk("active", 16'(e), 16'(o_act));
      chk("pid terminal", 16'(e ^ (i >= 8)), 16'(t_a));
      chk("refused", 16'(e && from_meas), 16'(o_ref));
      exp_val = e ? 16'(corr + (from_meas ? 16'h0000 : ms)) : ms;
      chk("speed", exp_val, o_speed);
    end
    $display("test enable and speed done");
    @(posedge clk);
    act <= 8'h28;
    in_sel <= 0;
    sel_a <= 8'h0E;
    sel_b <= 8'h73;
    for (int j = 0; j < 6; j++) begin
      for (int k = 0; k < 3; k++) begin
        @(posedge clk);
        kind <= 2'(j % 3);
        up <= j < 3 ? 14'h0258 : 14'h270F;
        lo <= j < 3 ? 14'h012C : 14'h270F;
        target <= tg[k];
        // unsigned draw keeps the set point inside 0..1000
        sp <= k == 0 ? 14'h270F : 14'($unsigned($random(seed)) % 1001);
        run();
        exp_val = sp == 14'h270F ? 16'h01F4 : 16'(sp);
        chk("set point", exp_val, 16'(o_sp));
        e = j < 3 && tg[k] > 10'h258;
        chk("upper", 16'(e), 16'(o_up));
        chk("upper terminal", 16'(!e), 16'(t_b));
        e = j < 3 && tg[k] < 10'h12C;
        chk("lower", 16'(e), 16'(o_lo));
        chk("lower terminal", 16'(e), 16'(t_a));
      end
    end
    $display("test limits done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sel_b <= i < 4 ? 8'h10 : 8'h74;
      fwd <= 1'($random(seed));
      kind <= 2'(1 + i % 2);
      target <= i % 4 < 2 ? 10'h3E8 : 10'h000;
      run();
      chk("forward", 16'(fwd), 16'(o_fwd));
      chk("fwd terminal", 16'(fwd ^ (i >= 4)), 16'(t_b));
      chk("percent", 16'(target), 16'(o_pct));
    end
    $display("test forward and scale done");
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule : dancer_pid_supervisor_bench
